// ### usb_ctrl_pkg.sv
// Package with register map, field positions and reset values of the control register group.
package usb_ctrl_pkg;
  // Register addresses on the 8-bit microprocessor port.
  localparam logic [7:0] ADDR_MAIN_CONTROL     = 8'h05;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_DEVICE_ADDRESS   = 8'h07;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_BUFFER_SET       = 8'h0e;
  localparam logic [7:0] ADDR_DMA_COUNT_LOW    = 8'h35;
  localparam logic [7:0] ADDR_DMA_COUNT_HIGH   = 8'h36;

  // Main control field positions.
  localparam int CTL_USB_ENABLE  = 0;
  localparam int CTL_DMA_ENABLE  = 1;
  localparam int CTL_DMA_DIR     = 2;
  localparam int CTL_FORCE_LOWER = 3;
  localparam int CTL_FORCE_UPPER = 4;
  localparam int CTL_SPEED       = 5;
  localparam int CTL_STANDBY     = 6;

  // Interrupt status and enable field positions.
  localparam int IRQ_DMA_BUSY  = 7;
  localparam int IRQ_BUS_RESET = 6;
  localparam int IRQ_SOF       = 5;
  localparam int IRQ_DMA_DONE  = 4;

  // Field masks; everything outside reads as zero, except bit seven of enable and status, which reads DMA busy.
  localparam logic [7:0] MAIN_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] IRQ_EVENT_MASK    = 8'h7f;
  localparam logic [7:0] BUFFER_SET_MASK   = 8'h0f;

  // Reset values.
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET   = 8'h00;
  localparam logic [7:0] DEVICE_ADDR_RESET  = 8'h00;
  localparam logic [7:0] ZERO_BYTE          = 8'h00;

  // Line force encodings (upper, lower).
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_SE0    = 2'h1;
  localparam logic [1:0] FORCE_K      = 2'h2;
  localparam logic [1:0] FORCE_J      = 2'h3;
endpackage

// ### line_force_drive.sv
// Bus line driver that turns the line force field into D+ and D- levels.
`timescale 1ns/1ps
module line_force_drive (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Control
  input  wire logic [1:0] line_force,
  // Line outputs
  output logic            dp_out,
  output logic            dp_oe,
  output logic            dm_out,
  output logic            dm_oe
);
  // Registered so the pins never glitch while the control byte is rewritten.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      dp_oe  <= 1'b0;
      dm_oe  <= 1'b0;
    end else begin
      unique case (line_force) // R05
        usb_ctrl_pkg::FORCE_NORMAL: begin
          dp_out <= 1'b0;
          dm_out <= 1'b0;
          dp_oe  <= 1'b0;
          dm_oe  <= 1'b0;
        end
        usb_ctrl_pkg::FORCE_SE0: begin
          dp_out <= 1'b0;
          dm_out <= 1'b0;
          dp_oe  <= 1'b1;
          dm_oe  <= 1'b1;
        end
        usb_ctrl_pkg::FORCE_K: begin
          dp_out <= 1'b0;
          dm_out <= 1'b1;
          dp_oe  <= 1'b1;
          dm_oe  <= 1'b1;
        end
        usb_ctrl_pkg::FORCE_J: begin
          dp_out <= 1'b1;
          dm_out <= 1'b0;
          dp_oe  <= 1'b1;
          dm_oe  <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ### usb_slave_control_irq_regs.sv
// Control and interrupt register group of the USB peripheral controller.
// Functional notes
// R01 - Software writes zero to control bit seven.
// R02 - Standby bit puts transceiver in low power.
// R03 - Suspend when standby set and enable clear.
// R04 - Speed bit: zero full, one low.
// R05 - Line force bits drive bus states.
// R06 - Line force bits clear at reset.
// R07 - Software forces K for remote wake-up.
// R08 - DMA direction: one reads out of device.
// R09 - DMA starts only on high count write.
// R10 - Global enable resets zero, gates transfers.
// R11 - Interrupt only for enabled pending events.
// R12 - Enable bits map bus reset, SOF, DMA, endpoints.
// R13 - Bit seven shows DMA in progress.
// R14 - DMA progress bit never raises interrupt.
// R15 - Device address resets to zero.
// R16 - Respond only to own device address.
// R17 - Status write one clears, zero keeps.
// R18 - Status latches reset, SOF, DMA, endpoint events.
// R19 - Read-only buffer set indicator per endpoint.
// R20 - Indicator bit n: zero first, one second.
// R21 - Software writes count low before high.
// R22 - Endpoint done sets regardless of enable.
// R23 - Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
module usb_slave_control_irq_regs #(
  parameter int ENDPOINTS = 4
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Microprocessor register port
  input  wire logic                 cs_n,
  input  wire logic                 wr_n,
  input  wire logic                 rd_n,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  output logic      [7:0]           rdata,
  // Events from the serial engine and DMA engine
  input  wire logic                 bus_reset_seen,
  input  wire logic                 sof_seen,
  input  wire logic                 dma_finished,
  input  wire logic [ENDPOINTS-1:0] endpoint_done,
  input  wire logic [ENDPOINTS-1:0] endpoint_set_select,
  // Token address check
  input  wire logic [6:0]           token_address,
  output logic                      address_match,
  // Interrupt request
  output logic                      interrupt_request_out,
  // Transceiver and engine control
  output logic                      transceiver_standby,
  output logic                      suspend_mode,
  output logic                      speed_select,
  output logic                      usb_enable,
  output logic                      dma_read_out,
  output logic                      dma_enable,
  output logic                      dma_start,
  output logic                      dma_busy,
  // Bus line drive
  output logic                      dp_out,
  output logic                      dp_oe,
  output logic                      dm_out,
  output logic                      dm_oe
);
  logic [7:0] main_control_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] device_address_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [ENDPOINTS-1:0] buffer_set_reg;
  logic       dma_busy_reg;
  logic       write_strobe;
  logic       read_strobe;
  logic [7:0] event_vector;
  logic [7:0] clear_vector;

  // Returns true when the given address equals the register address; the callers add the strobe.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // Strobes are level qualified and treated as synchronous to the clock.
  assign write_strobe = !cs_n && !wr_n;
  assign read_strobe  = !cs_n && !rd_n;

  // Main control register; bit seven is held zero whatever software writes.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      main_control_reg <= usb_ctrl_pkg::MAIN_CONTROL_RESET; // R06 R10
    end else if (write_strobe && hit(addr, usb_ctrl_pkg::ADDR_MAIN_CONTROL)) begin
      main_control_reg <= wdata & usb_ctrl_pkg::MAIN_CONTROL_MASK; // R01 R23
    end
  end

  // Control fields fanned out to the transceiver and engines.
  assign transceiver_standby = main_control_reg[usb_ctrl_pkg::CTL_STANDBY]; // R02
  assign usb_enable          = main_control_reg[usb_ctrl_pkg::CTL_USB_ENABLE]; // R10
  assign suspend_mode        = transceiver_standby && !usb_enable; // R03
  assign speed_select        = main_control_reg[usb_ctrl_pkg::CTL_SPEED]; // R04
  assign dma_read_out        = main_control_reg[usb_ctrl_pkg::CTL_DMA_DIR]; // R08
  assign dma_enable          = main_control_reg[usb_ctrl_pkg::CTL_DMA_ENABLE]; // R09

  // Interrupt enable register; bit seven is the live DMA busy flag, not storage.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_enable_reg <= usb_ctrl_pkg::IRQ_ENABLE_RESET;
    end else if (write_strobe && hit(addr, usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE)) begin
      irq_enable_reg <= wdata & usb_ctrl_pkg::IRQ_EVENT_MASK; // R12
    end
  end

  // Device address register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      device_address_reg <= usb_ctrl_pkg::DEVICE_ADDR_RESET; // R15
    end else if (write_strobe && hit(addr, usb_ctrl_pkg::ADDR_DEVICE_ADDRESS)) begin
      device_address_reg <= wdata;
    end
  end

  // Only tokens carrying our address are accepted, and only while the USB enable bit is set.
  assign address_match = usb_enable && (token_address == device_address_reg[6:0]); // R16

  // A count high write launches DMA only when DMA is enabled.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dma_start <= 1'b0;
    end else begin
      dma_start <= write_strobe && hit(addr, usb_ctrl_pkg::ADDR_DMA_COUNT_HIGH)
                   && dma_enable; // R09
    end
  end

  // Busy runs from launch until the DMA engine reports completion.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dma_busy_reg <= 1'b0;
    end else if (dma_start) begin
      dma_busy_reg <= 1'b1; // R13
    end else if (dma_finished) begin
      dma_busy_reg <= 1'b0; // R13
    end
  end
  assign dma_busy = dma_busy_reg;

  // Event vector in status layout; bit seven is never latched.
  always_comb begin
    event_vector = usb_ctrl_pkg::ZERO_BYTE;
    event_vector[usb_ctrl_pkg::IRQ_BUS_RESET] = bus_reset_seen; // R18
    event_vector[usb_ctrl_pkg::IRQ_SOF]       = sof_seen; // R18
    event_vector[usb_ctrl_pkg::IRQ_DMA_DONE]  = dma_finished; // R18
    event_vector[ENDPOINTS-1:0]               = endpoint_done; // R22
  end

  // Write-one-to-clear vector for the status register.
  always_comb begin
    clear_vector = usb_ctrl_pkg::ZERO_BYTE;
    if (write_strobe && hit(addr, usb_ctrl_pkg::ADDR_INTERRUPT_STATUS)) begin
      clear_vector = wdata & usb_ctrl_pkg::IRQ_EVENT_MASK; // R17
    end
  end

  // A new event beats a clear in the same cycle so no completion is lost.
  assign irq_status_next = (irq_status_reg & ~clear_vector) | event_vector; // R17 R22

  // Status latching ignores the enable bits entirely.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_status_reg <= usb_ctrl_pkg::ZERO_BYTE;
    end else begin
      irq_status_reg <= irq_status_next & usb_ctrl_pkg::IRQ_EVENT_MASK; // R11 R18
    end
  end

  // Request is the OR of enabled pending events; busy bit is masked out.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_request_out <= 1'b0;
    end else begin
      interrupt_request_out <= |(irq_status_reg & irq_enable_reg
                                 & usb_ctrl_pkg::IRQ_EVENT_MASK); // R11 R14
    end
  end

  // Current buffer set per endpoint, copied from the engine's selection.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      buffer_set_reg <= '0;
    end else begin
      buffer_set_reg <= endpoint_set_select; // R19 R20
    end
  end

  // Read data is registered; unmapped and reserved bits read zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= usb_ctrl_pkg::ZERO_BYTE;
    end else if (read_strobe) begin
      unique case (addr)
        usb_ctrl_pkg::ADDR_MAIN_CONTROL:     rdata <= main_control_reg;
        usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE: begin
          rdata <= {dma_busy_reg, irq_enable_reg[6:0]}; // R13
        end
        usb_ctrl_pkg::ADDR_DEVICE_ADDRESS:   rdata <= device_address_reg;
        usb_ctrl_pkg::ADDR_INTERRUPT_STATUS: begin
          rdata <= {dma_busy_reg, irq_status_reg[6:0]}; // R13 R17
        end
        usb_ctrl_pkg::ADDR_BUFFER_SET: begin
          rdata <= 8'(buffer_set_reg) & usb_ctrl_pkg::BUFFER_SET_MASK; // R19 R23
        end
        default: rdata <= usb_ctrl_pkg::ZERO_BYTE; // R23
      endcase
    end
  end

  // Pin driver for forced line states used for wake-up and reset signalling.
  line_force_drive u_line_force (
    .clock      (clock),
    .rst_n      (rst_n),
    .line_force ({main_control_reg[usb_ctrl_pkg::CTL_FORCE_UPPER],
                  main_control_reg[usb_ctrl_pkg::CTL_FORCE_LOWER]}), // R05 R07
    .dp_out     (dp_out),
    .dp_oe      (dp_oe),
    .dm_out     (dm_out),
    .dm_oe      (dm_oe)
  );
endmodule

// ### host_port_model.sv
// Host microprocessor model driving the register port.
`timescale 1ns/1ps
module host_port_model (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  // Bus idles with strobes high from time zero.
  initial begin
    {cs_n, wr_n, rd_n} = 3'h7;
    {addr, wdata} = 16'h0000;
  end
  // A write holds across the taking edge; the bus is then inverted so stale data never lingers.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {cs_n, wr_n, addr, wdata} <= {2'b00, a, d};
    @(posedge clock);
    {cs_n, wr_n, addr, wdata} <= {2'b11, ~a, ~d};
  endtask
  // A read waits one more edge for the registered answer.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    {cs_n, rd_n, addr} <= {2'b00, a};
    @(posedge clock);
    {cs_n, rd_n, addr} <= {2'b11, ~a};
    @(posedge clock);
    #1 d = rdata;
  endtask
  // Control writes keep the top bit clear.
  task automatic ctl(input logic [7:0] v);
    wr(usb_ctrl_pkg::ADDR_MAIN_CONTROL, v & 8'h7f);
  endtask
  // DMA count goes low byte first, high byte always.
  task automatic dma_go(input logic [7:0] lo, input logic [7:0] hi);
    wr(usb_ctrl_pkg::ADDR_DMA_COUNT_LOW, lo);
    wr(usb_ctrl_pkg::ADDR_DMA_COUNT_HIGH, hi);
  endtask
endmodule

// ### ctl_irq_props.sv
// Port checker for the control and interrupt register group.
`timescale 1ns/1ps
module ctl_irq_props (
  // Clock, reset and port
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  // Observed outputs and events
  input wire logic       dma_finished,
  input wire logic       address_match,
  input wire logic       interrupt_request_out,
  input wire logic       transceiver_standby,
  input wire logic       suspend_mode,
  input wire logic       speed_select,
  input wire logic       usb_enable,
  input wire logic       dma_read_out,
  input wire logic       dma_enable,
  input wire logic       dma_start,
  input wire logic       dma_busy,
  input wire logic       dp_out,
  input wire logic       dp_oe,
  input wire logic       dm_out,
  input wire logic       dm_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Write strobes decoded once for the properties below.
  wire wr_on = !cs_n && !wr_n;
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !usb_enable && !dp_oe
    && !dm_oe && !dma_busy && !interrupt_request_out) else $error("outputs live after reset");
  suspend_rule_a: assert property (suspend_mode == (transceiver_standby && !usb_enable))
    else $error("suspend mismatch");
  ctl_fields_a: assert property (wr_on && addr == usb_ctrl_pkg::ADDR_MAIN_CONTROL |=>
    {transceiver_standby, speed_select, dma_read_out, dma_enable, usb_enable}
    == $past({wdata[6:5], wdata[2:0]})) else $error("control field mismatch");
  dma_start_a: assert property (wr_on && addr == usb_ctrl_pkg::ADDR_DMA_COUNT_HIGH
    && dma_enable |=> dma_start) else $error("dma start missing");
  start_cause_a: assert property (dma_start |->
    $past(wr_on && addr == usb_ctrl_pkg::ADDR_DMA_COUNT_HIGH)) else $error("stray dma start");
  dma_busy_a: assert property (dma_start && !dma_finished |=> dma_busy)
    else $error("dma busy not set");
  match_enable_a: assert property (address_match |-> usb_enable)
    else $error("match while disabled");
  line_pair_a: assert property (dp_oe == dm_oe && !(dp_oe && dp_out && dm_out))
    else $error("line drive illegal");
  line_release_a: assert property (wr_on && addr == usb_ctrl_pkg::ADDR_MAIN_CONTROL
    && wdata[4:3] == 2'h0 |=> ##1 !dp_oe) else $error("line not released");
endmodule
bind usb_slave_control_irq_regs ctl_irq_props ctl_irq_props_i (.clock(clock), .rst_n(rst_n),
  .cs_n(cs_n), .wr_n(wr_n), .addr(addr), .wdata(wdata), .dma_finished(dma_finished),
  .address_match(address_match), .interrupt_request_out(interrupt_request_out),
  .transceiver_standby(transceiver_standby), .suspend_mode(suspend_mode),
  .speed_select(speed_select), .usb_enable(usb_enable), .dma_read_out(dma_read_out),
  .dma_enable(dma_enable), .dma_start(dma_start), .dma_busy(dma_busy), .dp_out(dp_out),
  .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe));

// ### usb_slave_control_irq_regs_test.sv
// Self-checking bench for the control and interrupt register group.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module usb_slave_control_irq_regs_test;
  logic       clock, rst_n, cs_n, wr_n, rd_n, address_match, interrupt_request_out;
  logic       transceiver_standby, suspend_mode, speed_select, usb_enable, dma_read_out;
  logic       dma_enable, dma_start, dma_busy, dp_out, dp_oe, dm_out, dm_oe;
  logic [7:0] addr, wdata, rdata, d, v, ex;
  logic [6:0] ev, token_address;
  logic [3:0] endpoint_set_select;
  int         n_fail, total_checks, cyc, seed, i;
  // Expected {oe, dp, dm} for a line force code; data is masked while released.
  function automatic logic [2:0] line_exp(input logic [1:0] c);
    return (c == 2'h0) ? 3'h0 : (c == 2'h1) ? 3'h4 : (c == 2'h2) ? 3'h5 : 3'h6;
  endfunction
  usb_slave_control_irq_regs usb_slave_control_irq_regs_i (.clock(clock), .rst_n(rst_n),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .wdata(wdata), .rdata(rdata),
    .bus_reset_seen(ev[6]), .sof_seen(ev[5]), .dma_finished(ev[4]), .endpoint_done(ev[3:0]),
    .endpoint_set_select(endpoint_set_select), .token_address(token_address),
    .address_match(address_match), .interrupt_request_out(interrupt_request_out),
    .transceiver_standby(transceiver_standby), .suspend_mode(suspend_mode),
    .speed_select(speed_select), .usb_enable(usb_enable), .dma_read_out(dma_read_out),
    .dma_enable(dma_enable), .dma_start(dma_start), .dma_busy(dma_busy), .dp_out(dp_out),
    .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe));
  host_port_model host_port_model_i (.clock(clock), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .addr(addr), .wdata(wdata), .rdata(rdata));
  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Counts and verdict, the single end of the run.
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard well above the few hundred cycles the tests need.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // One-cycle event pulse, then three edges for status and the lagging request.
  task automatic pulse(input logic [6:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 7'h00;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Main sequence.
  initial begin
    seed = 48588;
    {ev, token_address, endpoint_set_select, rst_n} = 19'h00000;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      host_port_model_i.rd(8'(8'h05 + (i < 3 ? i : i + 5)), d);
      `CHK(d, 8'h00)
    end
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = ($random(seed) & 8'h67) | (i[1:0] << 3);
      if (i == 7) host_port_model_i.wr(usb_ctrl_pkg::ADDR_MAIN_CONTROL, 8'hff);
      else host_port_model_i.ctl(v);
      if (i == 7) v = 8'hff;
      host_port_model_i.rd(usb_ctrl_pkg::ADDR_MAIN_CONTROL, d);
      `CHK(d, v & 8'h7f)
      `CHK({transceiver_standby, speed_select, dma_read_out, dma_enable}, {v[6:5], v[2:1]})
      `CHK({usb_enable, suspend_mode}, {v[0], v[6] & ~v[0]})
      `CHK({dp_oe, dp_oe & dp_out, dp_oe & dm_out}, line_exp(v[4:3]))
    end
    $display("test control done");
    host_port_model_i.ctl(8'h01);
    v = $random(seed);
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_DEVICE_ADDRESS, v);
    host_port_model_i.rd(usb_ctrl_pkg::ADDR_DEVICE_ADDRESS, d);
    `CHK(d, v)
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      token_address <= i ? ~v[6:0] : v[6:0];
      @(posedge clock);
      #1 `CHK(address_match, i == 0)
    end
    $display("test address done");
    ex = 8'h00;
    for (i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      ex[i] = 1'b1;
      host_port_model_i.rd(usb_ctrl_pkg::ADDR_INTERRUPT_STATUS, d);
      `CHK(d, ex)
      `CHK(interrupt_request_out, 1'b0)
    end
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE, 8'hff);
    pulse(7'h00);
    `CHK(interrupt_request_out, 1'b1)
    host_port_model_i.rd(usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE, d);
    `CHK(d, 8'h7f)
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_INTERRUPT_STATUS, 8'h0f);
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_INTERRUPT_STATUS, 8'h00);
    host_port_model_i.rd(usb_ctrl_pkg::ADDR_INTERRUPT_STATUS, d);
    `CHK(d, 8'h70)
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE, 8'h0f);
    pulse(7'h00);
    `CHK(interrupt_request_out, 1'b0)
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_INTERRUPT_STATUS, 8'hff);
    $display("test interrupt done");
    host_port_model_i.dma_go(8'h10, 8'h00);
    pulse(7'h00);
    `CHK(dma_busy, 1'b0)
    host_port_model_i.ctl(8'h03);
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE, 8'hef);
    host_port_model_i.dma_go(8'h10, 8'h00);
    pulse(7'h00);
    host_port_model_i.rd(usb_ctrl_pkg::ADDR_INTERRUPT_STATUS, d);
    `CHK({dma_busy, d, interrupt_request_out}, {1'b1, 8'h80, 1'b0})
    pulse(7'h10);
    host_port_model_i.rd(usb_ctrl_pkg::ADDR_INTERRUPT_ENABLE, d);
    `CHK({dma_busy, d, interrupt_request_out}, {1'b0, 8'h6f, 1'b0})
    $display("test dma done");
    @(posedge clock);
    endpoint_set_select <= 4'($random(seed));
    host_port_model_i.wr(usb_ctrl_pkg::ADDR_BUFFER_SET, 8'hff);
    host_port_model_i.rd(usb_ctrl_pkg::ADDR_BUFFER_SET, d);
    `CHK(d, {4'h0, endpoint_set_select})
    $display("test buffer set done");
    report_and_stop();
  end
endmodule
